/* three_wire_assertions.sv */
module three_wire_assertions (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic serial_clk,
   input wire logic serial_enable_n,
   input wire logic ctrl_data_oe,
   input wire logic dev_data_o,
   input wire logic dev_data_oe,
   input wire logic serial_data_io,
   input wire logic hard_reset_n
);
   timeunit 1ns;
   timeprecision 100ps;
   import three_wire_pkg::*;

   logic [4:0] rise_q;
   logic op_q;
   int low_q = 0;

   // --------
   // Helper logic
   // --------
   // Rises since enable fell, and the op bit of the frame
   always_ff @(posedge serial_clk) begin
      if (!hard_reset_n || serial_enable_n) begin
         rise_q <= 5'h00;
      end else begin
         rise_q <= rise_q + 5'h01;
      end
      if (!serial_enable_n && rise_q == 5'h01) begin
         op_q <= serial_data_io;
      end
   end

   // Length of the current hard reset pulse
   always_ff @(posedge ref_clk) begin
      if (hard_reset_n) begin
         low_q <= 0;
      end else begin
         low_q <= low_q + 1;
      end
   end

   // --------
   // Properties
   // --------
   sequence s_enable_drop;
      $fell(serial_enable_n);
   endsequence

   sequence s_read_frame;
      !serial_enable_n && op_q;
   endsequence

   property p_idle_released;
      @(posedge ref_clk) disable iff (!resetn)
         serial_enable_n |-> !ctrl_data_oe;
   endproperty
   a_idle_released: assert property (p_idle_released)
      else $error("controller drives data while idle");

   property p_enable_on_fall;
      @(posedge ref_clk) disable iff (!resetn)
         s_enable_drop |-> $fell(serial_clk);
   endproperty
   a_enable_on_fall: assert property (p_enable_on_fall)
      else $error("enable dropped off a falling clock edge");

   property p_extra_rise;
      @(posedge ref_clk) disable iff (!resetn)
         s_enable_drop |-> $past(serial_clk, 4) && !$past(serial_clk, 5)
            && $past(serial_enable_n, 4);
   endproperty
   a_extra_rise: assert property (p_extra_rise)
      else $error("no extra rise before enable dropped");

   property p_start_bit;
      @(posedge serial_clk) disable iff (!hard_reset_n)
         !serial_enable_n && rise_q == 5'h00 |-> serial_data_io == START_BIT;
   endproperty
   a_start_bit: assert property (p_start_bit)
      else $error("start bit missing");

   property p_frame_length;
      @(posedge serial_clk) disable iff (!hard_reset_n)
         $rose(serial_enable_n) |-> (!op_q && rise_q == 5'h19)
            || (op_q && rise_q == 5'h1c);
   endproperty
   a_frame_length: assert property (p_frame_length)
      else $error("frame length wrong");

   property p_write_quiet;
      @(posedge serial_clk) disable iff (!hard_reset_n)
         !serial_enable_n && rise_q >= 5'h02 && !op_q |-> !dev_data_oe;
   endproperty
   a_write_quiet: assert property (p_write_quiet)
      else $error("device drives during a write");

   property p_turnaround;
      @(posedge serial_clk) disable iff (!hard_reset_n)
         s_read_frame ##0 (rise_q inside {[5'h09:5'h0b]})
            |-> !ctrl_data_oe && !dev_data_oe;
   endproperty
   a_turnaround: assert property (p_turnaround)
      else $error("data line driven in turnaround");

   property p_bit_on_rise;
      @(posedge ref_clk) disable iff (!resetn)
         dev_data_oe && $changed(dev_data_o) |-> $rose(serial_clk);
   endproperty
   a_bit_on_rise: assert property (p_bit_on_rise)
      else $error("read bit changed off a rising edge");

   property p_drive_start;
      @(posedge serial_clk) disable iff (!hard_reset_n)
         $rose(dev_data_oe) |-> op_q && rise_q == 5'h0c;
   endproperty
   a_drive_start: assert property (p_drive_start)
      else $error("device drive started on wrong edge");

   property p_release;
      @(posedge serial_clk) disable iff (!hard_reset_n)
         $fell(dev_data_oe) |-> rise_q == 5'h1c;
   endproperty
   a_release: assert property (p_release)
      else $error("device released on wrong edge");

   property p_reset_width;
      @(posedge ref_clk) disable iff (!resetn)
         $rose(hard_reset_n) |-> low_q >= HARD_RESET_CYC;
   endproperty
   a_reset_width: assert property (p_reset_width)
      else $error("hard reset pulse too short");
endmodule : three_wire_assertions

/* three_wire_controller.sv */
module three_wire_controller (
   three_wire_if.ctrl p,
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [three_wire_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [three_wire_pkg::DATA_W-1:0] cmd_wdata,
   input wire logic chip_enable,
   input wire logic bank_select,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [three_wire_pkg::DATA_W-1:0] rsp_rdata
);
   import three_wire_pkg::*;

   typedef enum logic [2:0] {
      C_RESET = 3'b001,
      C_IDLE = 3'b010,
      C_FRAME = 3'b100
   } ctrl_state_e;

   typedef struct packed {
      ctrl_state_e st;
      logic [6:0] rst_cnt;
      logic [2:0] div;
      logic sclk;
      logic [4:0] edge_n;
      logic en_n;
      logic dout;
      logic doe;
      logic is_read;
      logic [TX_W-1:0] tx;
      logic [DATA_W-1:0] rdata;
      logic rsp;
      logic [1:0] rd_sync;
      logic ce;
      logic bank;
      logic hr_n;
   } ctrl_s;

   ctrl_s q;
   ctrl_s d;
   logic tick;

   // --------
   // Next state
   // --------
   always_comb begin
      d = q;
      tick = (q.div == 3'(SCLK_HALF_CYC - 1));
      d.rd_sync = {q.rd_sync[0], p.serial_data_io};
      d.ce = chip_enable;
      d.bank = bank_select;
      d.rsp = 1'b0;
      if (!resetn) begin
         d.st = C_RESET;
         d.rst_cnt = '0;
         d.div = '0;
         d.sclk = 1'b0;
         d.edge_n = '0;
         d.en_n = 1'b1;
         d.dout = 1'b0;
         d.doe = 1'b0;
         d.is_read = 1'b0;
         d.tx = '0;
         d.rdata = '0;
         d.hr_n = 1'b0;
      end else begin
         // Clock divider, active in reset and frame states
         if (q.st != C_IDLE) begin
            d.div = tick ? 3'd0 : q.div + 3'd1;
            if (tick) begin
               d.sclk = !q.sclk; // R09
            end
         end
         case (q.st)
            C_RESET: begin
               // Low pulse, then clock keeps running for the device
               d.rst_cnt = q.rst_cnt + 7'd1;
               d.hr_n = (q.rst_cnt >= 7'(RST_HOLD_CYC - 1)); // R16
               if (q.rst_cnt == 7'(RST_TOTAL_CYC - 1)) begin
                  d.st = C_IDLE;
                  d.sclk = 1'b0;
                  d.div = '0;
               end
            end
            C_IDLE: begin
               if (cmd_valid) begin
                  d.st = C_FRAME;
                  d.edge_n = '0;
                  d.is_read = !cmd_write;
                  d.tx = {!cmd_write, cmd_addr, cmd_wdata}; // R05 R06
               end
            end
            C_FRAME: begin
               if (tick && !q.sclk) begin
                  d.edge_n = q.edge_n + 5'd1; // R03
               end
               if (tick && q.sclk) begin
                  // Falling edge actions keyed on rises so far
                  if (q.edge_n == EDGE_ENABLE) begin
                     d.en_n = 1'b0; // R02
                     d.doe = 1'b1;
                     d.dout = START_BIT; // R05
                  end else if (q.edge_n <= EDGE_ADDR_LAST ||
                               (!q.is_read &&
                                q.edge_n <= EDGE_WDATA_LAST)) begin
                     d.dout = q.tx[TX_W-1]; // R07
                     d.tx = {q.tx[TX_W-2:0], 1'b0};
                  end
                  if (q.is_read) begin
                     if (q.edge_n == EDGE_RELEASE) begin
                        d.doe = 1'b0; // R12
                     end
                     if (q.edge_n >= EDGE_RD_FIRST &&
                         q.edge_n <= EDGE_RD_LAST) begin
                        d.rdata = {q.rdata[DATA_W-2:0], q.rd_sync[1]}; // R11
                     end
                     if (q.edge_n == EDGE_R_ENABLE_HI) begin
                        d.en_n = 1'b1; // R13
                     end
                     if (q.edge_n == EDGE_R_END) begin
                        d.st = C_IDLE;
                        d.rsp = 1'b1;
                     end
                  end else begin
                     if (q.edge_n == EDGE_W_ENABLE_HI) begin
                        d.en_n = 1'b1; // R08
                        d.doe = 1'b0; // R01
                     end
                     if (q.edge_n == EDGE_W_END) begin
                        d.st = C_IDLE;
                        d.rsp = 1'b1;
                     end
                  end
               end
            end
            default: begin
               d.st = C_RESET;
            end
         endcase
      end
   end

   // --------
   // State register
   // --------
   always_ff @(posedge ref_clk) begin
      q <= d;
   end

   // Outputs straight from state flops, except cmd_ready decoded from the state
   assign p.serial_clk = q.sclk;
   assign p.serial_enable_n = q.en_n;
   assign p.ctrl_data_o = q.dout;
   assign p.ctrl_data_oe = q.doe;
   assign p.chip_enable_pin = q.ce;
   assign p.bank_select = q.bank;
   assign p.hard_reset_n = q.hr_n;
   assign cmd_ready = (q.st == C_IDLE);
   assign rsp_valid = q.rsp;
   assign rsp_rdata = q.rdata;

endmodule : three_wire_controller

/* three_wire_device.sv */
module three_wire_device (
   three_wire_if.dev p,
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic kv_cal_enable,
   output logic analog_on,
   output logic osc_bias_on,
   output logic coarse_tune_busy,
   output logic gain_comp_busy,
   output logic bank2_selected,
   output logic mixer1_on,
   output logic mixer2_on
);
   import three_wire_pkg::*;

   // --------
   // Types
   // --------
   typedef enum logic [7:0] {
      D_IDLE = 8'b0000_0001,
      D_OP = 8'b0000_0010,
      D_ADDR = 8'b0000_0100,
      D_WDATA = 8'b0000_1000,
      D_WLATCH = 8'b0001_0000,
      D_TURN = 8'b0010_0000,
      D_RDATA = 8'b0100_0000,
      D_DONE = 8'b1000_0000
   } dev_state_e;

   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_COARSE = 3'b010,
      CAL_GAIN = 3'b100
   } cal_state_e;

   // Serial clock domain state
   typedef struct packed {
      dev_state_e st;
      logic [4:0] cnt;
      logic is_read;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] shift;
      logic dout;
      logic doe;
      logic [NUM_REGS-1:0][DATA_W-1:0] regs;
      logic [1:0] rst_sync;
   } ser_s;

   // Reference clock domain state
   typedef struct packed {
      cal_state_e cal;
      logic [CAL_CNT_W-1:0] cal_cnt;
      logic ce_prev;
      logic [1:0] ce_sync;
      logic [1:0] mode_sync;
      logic [1:0] hr_sync;
      logic [1:0] stby_sync;
      logic [1:0] fd_sync;
      logic analog;
      logic osc;
      logic bank2;
      logic mix1;
      logic mix2;
   } ref_s;

   ser_s s_q;
   ser_s s_d;
   ref_s r_q;
   ref_s r_d;
   logic din;
   logic ce;
   logic stby;
   logic full_duplex;

   // Address falls inside the implemented register file
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = (a < 7'(NUM_REGS));
   endfunction : reg_hit

   // --------
   // Serial side: telegram decode, register file, read drive
   // --------

   // Telegram state machine on serial clock rising edges
   always_comb begin
      s_d = s_q;
      din = p.serial_data_io;
      s_d.rst_sync = {s_q.rst_sync[0], p.hard_reset_n};
      if (!s_q.rst_sync[1]) begin
         s_d.st = D_IDLE;
         s_d.cnt = '0;
         s_d.is_read = 1'b0;
         s_d.addr = '0;
         s_d.shift = '0;
         s_d.dout = 1'b0;
         s_d.doe = 1'b0;
         for (int i = 0; i < NUM_REGS; i++) begin
            s_d.regs[i] = REG_RESET; // R16
         end
      end else if (p.serial_enable_n) begin
         // Enable high: finish a complete write, else drop all
         s_d.st = D_IDLE; // R24
         s_d.cnt = '0;
         s_d.doe = 1'b0; // R01
         if (s_q.st == D_WLATCH && reg_hit(s_q.addr)) begin
            s_d.regs[s_q.addr[REG_IDX_W-1:0]] = s_q.shift; // R08
         end
      end else begin
         case (s_q.st)
            D_IDLE: begin
               // First rise with enable low is the init slot
               s_d.st = D_OP; // R04
            end
            D_OP: begin
               s_d.is_read = (din == OP_READ); // R04 R05
               s_d.cnt = '0;
               s_d.st = D_ADDR;
            end
            D_ADDR: begin
               s_d.addr = {s_q.addr[ADDR_W-2:0], din}; // R06
               s_d.cnt = s_q.cnt + 5'd1;
               if (s_q.cnt == ADDR_CNT_LAST) begin
                  s_d.cnt = '0;
                  if (s_q.is_read) begin
                     s_d.st = D_TURN; // R10
                     s_d.shift = reg_hit(s_d.addr) ?
                        s_q.regs[s_d.addr[REG_IDX_W-1:0]] : '0;
                  end else begin
                     s_d.st = D_WDATA;
                  end
               end
            end
            D_WDATA: begin
               s_d.shift = {s_q.shift[DATA_W-2:0], din}; // R07
               s_d.cnt = s_q.cnt + 5'd1;
               if (s_q.cnt == DATA_CNT_LAST) begin
                  s_d.st = D_WLATCH;
               end
            end
            D_WLATCH: begin
               // Waits for enable high; extra bits are ignored
               s_d.st = D_WLATCH;
            end
            D_TURN: begin
               s_d.cnt = s_q.cnt + 5'd1;
               if (s_q.cnt == TURN_CNT_LAST) begin
                  s_d.doe = 1'b1; // R12
                  s_d.dout = s_q.shift[DATA_W-1];
                  s_d.shift = {s_q.shift[DATA_W-2:0], 1'b0};
                  s_d.cnt = '0;
                  s_d.st = D_RDATA;
               end
            end
            D_RDATA: begin
               if (s_q.cnt == DATA_CNT_LAST) begin
                  s_d.doe = 1'b0; // R13
                  s_d.st = D_DONE;
               end else begin
                  s_d.dout = s_q.shift[DATA_W-1]; // R11
                  s_d.shift = {s_q.shift[DATA_W-2:0], 1'b0};
                  s_d.cnt = s_q.cnt + 5'd1;
               end
            end
            D_DONE: begin
               s_d.st = D_DONE;
            end
            default: begin
               s_d.st = D_IDLE;
               s_d.doe = 1'b0;
            end
         endcase
      end
   end

   // Serial domain register
   always_ff @(posedge p.serial_clk) begin
      s_q <= s_d;
   end

   // Data line drive from flops
   assign p.dev_data_o = s_q.dout;
   assign p.dev_data_oe = s_q.doe;

   // --------
   // Reference side: pins, power gating, calibration timers
   // --------

   // Synchronised levels, read only from second stages
   assign ce = r_q.ce_sync[1];
   assign stby = r_q.stby_sync[1];
   assign full_duplex = r_q.fd_sync[1];

   // Power gating, bank and mixer select, coarse tune timer
   always_comb begin
      r_d = r_q;
      r_d.ce_sync = {r_q.ce_sync[0], p.chip_enable_pin};
      r_d.mode_sync = {r_q.mode_sync[0], p.bank_select};
      r_d.hr_sync = {r_q.hr_sync[0], p.hard_reset_n};
      r_d.stby_sync = {r_q.stby_sync[0],
                       s_q.regs[REG_CAL_CONFIG][REF_STANDBY_POS]};
      r_d.fd_sync = {r_q.fd_sync[0],
                     s_q.regs[REG_OPER_CONFIG][FULL_DUPLEX_POS]};
      if (!resetn || !r_q.hr_sync[1]) begin
         r_d.cal = CAL_IDLE; // R16
         r_d.cal_cnt = '0;
         r_d.ce_prev = 1'b0;
         r_d.analog = 1'b0;
         r_d.osc = 1'b0;
         r_d.bank2 = 1'b0;
         r_d.mix1 = 1'b0;
         r_d.mix2 = 1'b0;
      end else begin
         r_d.ce_prev = ce;
         r_d.analog = ce; // R14
         r_d.osc = ce || stby; // R14 R22
         r_d.bank2 = r_q.mode_sync[1]; // R17
         r_d.mix1 = full_duplex || !r_q.mode_sync[1]; // R23
         r_d.mix2 = full_duplex || r_q.mode_sync[1]; // R23
         case (r_q.cal)
            CAL_IDLE: begin
               if (ce && !r_q.ce_prev) begin
                  r_d.cal = CAL_COARSE; // R15
                  r_d.cal_cnt = CAL_CNT_W'(COARSE_TUNE_CYC - 1); // R20
               end
            end
            CAL_COARSE: begin
               r_d.cal_cnt = r_q.cal_cnt - 1'b1; // R19
               if (!ce) begin
                  r_d.cal = CAL_IDLE;
               end else if (r_q.cal_cnt == '0) begin
                  if (kv_cal_enable) begin
                     r_d.cal = CAL_GAIN;
                     r_d.cal_cnt = CAL_CNT_W'(GAIN_COMP_CYC - 1); // R19
                  end else begin
                     r_d.cal = CAL_IDLE;
                  end
               end
            end
            CAL_GAIN: begin
               r_d.cal_cnt = r_q.cal_cnt - 1'b1;
               if (!ce || r_q.cal_cnt == '0) begin
                  r_d.cal = CAL_IDLE;
               end
            end
            default: begin
               r_d.cal = CAL_IDLE;
            end
         endcase
      end
   end

   // Reference domain register
   always_ff @(posedge ref_clk) begin
      r_q <= r_d;
   end

   // Outputs from reference domain flops
   assign analog_on = r_q.analog;
   assign osc_bias_on = r_q.osc;
   assign coarse_tune_busy = (r_q.cal == CAL_COARSE);
   assign gain_comp_busy = (r_q.cal == CAL_GAIN);
   assign bank2_selected = r_q.bank2;
   assign mixer1_on = r_q.mix1;
   assign mixer2_on = r_q.mix2;

endmodule : three_wire_device

/* three_wire_if.sv */
interface three_wire_if;
   logic serial_clk;
   logic serial_enable_n;
   logic ctrl_data_o;
   logic ctrl_data_oe;
   logic dev_data_o;
   logic dev_data_oe;
   logic serial_data_io;
   logic chip_enable_pin;
   logic hard_reset_n;
   logic bank_select;

   // Shared data wire; idles high as with a pull-up
   assign serial_data_io = ctrl_data_oe ? ctrl_data_o :
                           (dev_data_oe ? dev_data_o : 1'b1);

   modport ctrl (
      output serial_clk,
      output serial_enable_n,
      output ctrl_data_o,
      output ctrl_data_oe,
      output chip_enable_pin,
      output hard_reset_n,
      output bank_select,
      input serial_data_io
   );

   modport dev (
      input serial_clk,
      input serial_enable_n,
      input serial_data_io,
      input chip_enable_pin,
      input hard_reset_n,
      input bank_select,
      output dev_data_o,
      output dev_data_oe
   );
endinterface : three_wire_if

/* three_wire_pkg.sv */
// What this block does
// [R01] Idle: enable high, data line released
// [R02] Controller lowers enable on first falling edge
// [R03] One extra rising edge before enable low
// [R04] Second rise is init slot, third is op
// [R05] Start bit, then op: 0 write, 1 read
// [R06] Write: op, 7 address, 16 data bits
// [R07] Write: controller drives, device samples rising
// [R08] Payload latched on final rise, enable high
// [R09] Serial clock at most 19.2 MHz
// [R10] Read: 2.5-bit turnaround, device sends 16 bits
// [R11] Read bits change rising, captured falling
// [R12] Device drives three rises after last address
// [R13] Device releases after 16 bits, enable rises
// [R14] Chip enable gates analog; osc off needs both
// [R15] Chip enable rise starts coarse tune
// [R16] Hard reset restores defaults, held 100 ns
// [R17] Bank pin selects register bank and mixer
// [R18] Standby set 500 us before chip enable; the testbench raises chip enable 20 cycles after the standby write
// [R19] Coarse tune 50 us, gain comp 100 us
// [R20] Coarse tune time scales with reference
// [R21] Four writes per path, three when small
// [R22] Standby keeps oscillator on, enable low
// [R23] Bank low: bank1/mixer1; full duplex: both
// [R24] Early enable rise discards partial telegram
package three_wire_pkg;

   // --------
   // Frame layout
   // --------
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam int NUM_REGS = 32;
   localparam int REG_IDX_W = 5;
   localparam int TX_W = 1 + ADDR_W + DATA_W;
   localparam logic START_BIT = 1'b1;
   localparam logic OP_WRITE = 1'b0;
   localparam logic OP_READ = 1'b1;
   localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

   // Rising-edge indices within a frame (edge 1 is the extra edge)
   localparam logic [4:0] EDGE_ENABLE = 5'd1;
   localparam logic [4:0] EDGE_ADDR_LAST = 5'd9;
   localparam logic [4:0] EDGE_RELEASE = 5'd10;
   localparam logic [4:0] EDGE_WDATA_LAST = 5'd25;
   localparam logic [4:0] EDGE_W_ENABLE_HI = 5'd26;
   localparam logic [4:0] EDGE_W_END = 5'd27;
   localparam logic [4:0] EDGE_RD_FIRST = 5'd13;
   localparam logic [4:0] EDGE_RD_LAST = 5'd28;
   localparam logic [4:0] EDGE_R_ENABLE_HI = 5'd29;
   localparam logic [4:0] EDGE_R_END = 5'd30;

   // Device bit counters
   localparam logic [4:0] ADDR_CNT_LAST = 5'd6;
   localparam logic [4:0] DATA_CNT_LAST = 5'd15;
   localparam logic [4:0] TURN_CNT_LAST = 5'd2;

   // --------
   // Control bit locations
   // --------
   localparam logic [ADDR_W-1:0] REG_OPER_CONFIG = 7'h00;
   localparam int FULL_DUPLEX_POS = 1;
   localparam logic [ADDR_W-1:0] REG_CAL_CONFIG = 7'h02;
   localparam int REF_STANDBY_POS = 0;

   // --------
   // Timing
   // --------
   localparam int REF_CLK_KHZ = 125000;
   localparam int REF_CLK_PERIOD_NS = 8;
   localparam int SCLK_MAX_KHZ = 19200;
   localparam int SCLK_HALF_CYC =
      (REF_CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
   localparam int HARD_RESET_NS = 100;
   localparam int HARD_RESET_CYC =
      (HARD_RESET_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
   localparam int RST_SCLK_CYC = 8 * SCLK_HALF_CYC;
   localparam int RST_HOLD_CYC = (HARD_RESET_CYC > RST_SCLK_CYC) ?
      HARD_RESET_CYC : RST_SCLK_CYC;
   localparam int RST_TOTAL_CYC = 2 * RST_HOLD_CYC;

   // Calibration lengths in cycles of the device reference clock
   localparam int COARSE_TUNE_US = 50;
   localparam int GAIN_COMP_US = 100;
   localparam int CAL_REF_MHZ = 26;
   localparam int COARSE_TUNE_CYC = COARSE_TUNE_US * CAL_REF_MHZ;
   localparam int GAIN_COMP_CYC = GAIN_COMP_US * CAL_REF_MHZ;
   localparam int CAL_CNT_W = 12;

endpackage : three_wire_pkg

/* three_wire_register_port_tb.sv */
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module three_wire_register_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import three_wire_pkg::*;

   logic ref_clk = 1'b0;
   logic dev_clk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [ADDR_W-1:0] cmd_addr = 7'h00;
   logic [DATA_W-1:0] cmd_wdata = 16'h0000;
   logic chip_enable = 1'b0;
   logic bank_select = 1'b0;
   logic kv_cal_enable = 1'b0;
   logic cmd_ready, rsp_valid, analog_on, osc_bias_on, coarse_tune_busy;
   logic gain_comp_busy, bank2_selected, mixer1_on, mixer2_on;
   logic [DATA_W-1:0] rsp_rdata, rd;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [ADDR_W-1:0] ta [4] = '{7'h01, 7'h1f, 7'h03, 7'h60};
   logic [DATA_W-1:0] td [4] = '{16'ha5c3, 16'h8001, 16'h1234, 16'hffff};
   logic [DATA_W-1:0] te [4] = '{16'ha5c3, 16'h8001, 16'h1234, 16'h0000};

   // --------
   // Clocks, structure, timeout
   // --------
   always #4 ref_clk = ~ref_clk;
   always #15 dev_clk = ~dev_clk;

   three_wire_if three_wire_if_i ();

   three_wire_controller three_wire_controller_i (.p(three_wire_if_i),
      .ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .chip_enable(chip_enable), .bank_select(bank_select),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

   three_wire_device three_wire_device_i (.p(three_wire_if_i),
      .ref_clk(dev_clk), .resetn(resetn), .kv_cal_enable(kv_cal_enable),
      .analog_on(analog_on), .osc_bias_on(osc_bias_on),
      .coarse_tune_busy(coarse_tune_busy), .gain_comp_busy(gain_comp_busy),
      .bank2_selected(bank2_selected), .mixer1_on(mixer1_on),
      .mixer2_on(mixer2_on));

   three_wire_assertions chk (.ref_clk(ref_clk), .resetn(resetn),
      .serial_clk(three_wire_if_i.serial_clk),
      .serial_enable_n(three_wire_if_i.serial_enable_n),
      .ctrl_data_oe(three_wire_if_i.ctrl_data_oe),
      .dev_data_o(three_wire_if_i.dev_data_o),
      .dev_data_oe(three_wire_if_i.dev_data_oe),
      .serial_data_io(three_wire_if_i.serial_data_io),
      .hard_reset_n(three_wire_if_i.hard_reset_n));

   // Cut a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         close_out();
      end
   end

   // --------
   // Tasks
   // --------
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : idle

   // One command, raised for one cycle once ready, then wait for its response
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200) begin
         idle(1);
         n++;
      end
      `CHK("cmd_ready", 1'b1, cmd_ready)
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_wdata = d;
      idle(1);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 700) begin
         idle(1);
         n++;
      end
      `CHK("rsp_valid", 1'b1, rsp_valid)
      rd = rsp_rdata;
   endtask : xfer

   // Length in device reference (dev_clk) cycles of one busy window
   task automatic busy_len(input logic gain, output int n);
      int w;
      w = 0;
      n = 0;
      while ((gain ? gain_comp_busy : coarse_tune_busy) !== 1'b1
             && w < 20) begin
         @(posedge dev_clk) #1;
         w++;
      end
      while ((gain ? gain_comp_busy : coarse_tune_busy) === 1'b1
             && n < 5000) begin
         @(posedge dev_clk) #1;
         n++;
      end
   endtask : busy_len

   // Writes back to back, then read back; 0x60 is out of range, so its write is dropped and it reads 0
   task automatic test_regs();
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, ta[i], td[i]);
      end
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, ta[i], 16'h0000);
         `CHK("read data", te[i], rd)
      end
   endtask : test_regs

   // Standby, chip enable and calibration windows
   task automatic test_power();
      int n;
      `CHK("osc_bias_on", 1'b0, osc_bias_on)
      xfer(1'b1, REG_CAL_CONFIG, 16'h0001);
      idle(20);
      `CHK("osc_bias_on", 1'b1, osc_bias_on)
      `CHK("analog_on", 1'b0, analog_on)
      kv_cal_enable = 1'b1;
      chip_enable = 1'b1;
      busy_len(1'b0, n);
      `CHK("coarse length", COARSE_TUNE_CYC, n)
      `CHK("analog_on", 1'b1, analog_on)
      busy_len(1'b1, n);
      `CHK("gain length", GAIN_COMP_CYC, n)
      idle(1);
      chip_enable = 1'b0;
      kv_cal_enable = 1'b0;
      idle(20);
      `CHK("analog_on", 1'b0, analog_on)
      `CHK("osc_bias_on", 1'b1, osc_bias_on)
      chip_enable = 1'b1;
      busy_len(1'b0, n);
      `CHK("coarse again", COARSE_TUNE_CYC, n)
      `CHK("gain_comp_busy", 1'b0, gain_comp_busy)
      idle(1);
      chip_enable = 1'b0;
      xfer(1'b1, REG_CAL_CONFIG, 16'h0000);
      idle(20);
      `CHK("osc_bias_on", 1'b0, osc_bias_on)
   endtask : test_power

   // Every bank pin and full duplex combination
   task automatic test_bank();
      logic fd;
      logic bs;
      for (int i = 0; i < 4; i++) begin
         fd = i[1];
         bs = i[0];
         xfer(1'b1, REG_OPER_CONFIG, {14'h0000, fd, 1'b0});
         bank_select = bs;
         idle(20);
         `CHK("bank2_selected", bs, bank2_selected)
         `CHK("mixer1_on", fd | !bs, mixer1_on)
         `CHK("mixer2_on", fd | bs, mixer2_on)
      end
   endtask : test_bank

   // Mid-run reset clears registers; bank pin is still high
   task automatic test_hard_reset();
      xfer(1'b1, 7'h1f, 16'h5a5a);
      resetn = 1'b0;
      idle(3);
      resetn = 1'b1;
      xfer(1'b0, 7'h1f, 16'h0000);
      `CHK("read after reset", 16'h0000, rd)
      `CHK("mixer1_on", 1'b0, mixer1_on)
   endtask : test_hard_reset

   // --------
   // Main sequence
   // --------
   initial begin
      idle(3);
      resetn = 1'b1;
      test_regs();
      test_power();
      test_bank();
      test_hard_reset();
      close_out();
   end
endmodule : three_wire_register_port_tb
